/* verilog/lecfg_defs.vh */
// Summary of operation
// - With its hold bit set, an error counter stops at 0xFF until cleared.
// - With its hold bit clear, an error counter wraps from 0xFF to zero.
// - Field bit 2 is control char, bit 1 bad code, bit 0 disparity.
// - After reset every lane's hold field reads 0x7.
// - Lanes 1 to 4 each have a byte register, 0x489 through 0x48C.
// - Each counter counts only while its own per-counter enable bit is set.
// - A per-counter clear bit zeroes its counter, releasing a held counter.
`ifndef LECFG_DEFS_VH
`define LECFG_DEFS_VH
`define LECFG_ADDR_LANE1     12'h0489
`define LECFG_ADDR_LANE2     12'h048A
`define LECFG_ADDR_LANE3     12'h048B
`define LECFG_ADDR_LANE4     12'h048C
`define LECFG_ADDR_LANE5     12'h048D
`define LECFG_HOLD_RESET     3'h7
`define LECFG_CNT_MAX        8'hFF
`define LECFG_BIT_CTRL_CHAR  2
`define LECFG_BIT_BAD_CODE   1
`define LECFG_BIT_DISPARITY  0
`endif

/* verilog/lecfg_counter.v */
`timescale 1ns/1ps
`default_nettype none
`include "lecfg_defs.vh"
module lecfg_counter (
    input  wire       clk_sys_in,
    input  wire       rst_in,
    input  wire       event_in,
    input  wire       enable_in,
    input  wire       clear_in,
    input  wire       hold_in,
    output reg  [7:0] count_out
);
    always @(posedge clk_sys_in) begin
        if (rst_in || clear_in) begin
            count_out <= 8'h00;
        end else if (event_in && enable_in) begin
            if (count_out == `LECFG_CNT_MAX && hold_in) begin
                count_out <= count_out;
            end else begin
                count_out <= count_out + 8'h01;
            end
        end
    end
endmodule // lecfg_counter
`default_nettype wire

/* verilog/lecfg_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "lecfg_defs.vh"

module lecfg_top (
    // Configuration port
    input  wire        clk_sys_in,
    input  wire        rst_in,
    input  wire        cfg_wr_in,
    input  wire        cfg_rd_in,
    input  wire [11:0] cfg_addr_in,
    input  wire [7:0]  cfg_wdata_in,
    output reg  [7:0]  cfg_rdata_out,
    // Error events and per-counter controls, three bits per lane
    input  wire [11:0] err_event_in,
    input  wire [11:0] cnt_enable_in,
    input  wire [11:0] cnt_clear_in,
    // Counter values and the hold fields that steer them
    output wire [95:0] err_count_out,
    output reg  [11:0] hold_bits_out
);

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    // Fixed by the register map: four lanes of three counters each
    localparam integer LANES   = 4;
    localparam integer FIELD_W = 3;
    localparam integer CNT_W   = 8;
    localparam integer LANE_CW = FIELD_W * CNT_W;

    // Position of each counter kind inside a lane's three-bit field
    localparam integer K_CC    = `LECFG_BIT_CTRL_CHAR;
    localparam integer K_BC    = `LECFG_BIT_BAD_CODE;
    localparam integer K_RD    = `LECFG_BIT_DISPARITY;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // One decode serves both the write and the read path, so a
    // register can never be written at one address and read at
    // another
    function [3:0] lane_sel;
        input [11:0] addr;
        begin
            case (addr)
                `LECFG_ADDR_LANE1: lane_sel = 4'b0001;
                `LECFG_ADDR_LANE2: lane_sel = 4'b0010;
                `LECFG_ADDR_LANE3: lane_sel = 4'b0100;
                `LECFG_ADDR_LANE4: lane_sel = 4'b1000;
                default:           lane_sel = 4'b0000;
            endcase
        end
    endfunction

    // Picks the field of the selected lane; an empty selection gives
    // zero, which is what an unmapped address reads back
    function [2:0] field_of;
        input [11:0] hold;
        input [3:0]  sel;
        begin
            case (sel)
                4'b0001: field_of = hold[2:0];
                4'b0010: field_of = hold[5:3];
                4'b0100: field_of = hold[8:6];
                4'b1000: field_of = hold[11:9];
                default: field_of = 3'h0;
            endcase
        end
    endfunction

    wire [3:0]  wr_sel;
    wire [3:0]  rd_sel;

    assign wr_sel = lane_sel(cfg_addr_in) & {4{cfg_wr_in}};
    assign rd_sel = lane_sel(cfg_addr_in);

    // ------------------------------------------------------------
    // Hold registers
    // ------------------------------------------------------------
    // Writes are taken at any time. Keeping them to decoder soft
    // reset is left to software: a change mid-run can freeze a
    // counter that was meant to wrap, or let a held one wrap, from
    // that edge on
    wire [11:0] hold_d;

    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_hold
            // Only the three field bits are stored; 7 to 3 are dropped
            assign hold_d[FIELD_W*g +: FIELD_W] = wr_sel[g] ?
                cfg_wdata_in[2:0] :
                hold_bits_out[FIELD_W*g +: FIELD_W];
        end
    endgenerate

    // One process for all lanes keeps a single driver on the output
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            hold_bits_out <= {LANES{`LECFG_HOLD_RESET}};
        end else begin
            hold_bits_out <= hold_d;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read data is registered and stands until the next read strobe
    reg [7:0] rdata_d;

    always @* begin
        rdata_d      = 8'h00;
        rdata_d[2:0] = field_of(hold_bits_out, rd_sel);
    end

    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            cfg_rdata_out <= 8'h00;
        end else if (cfg_rd_in) begin
            cfg_rdata_out <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Error counters
    // ------------------------------------------------------------
    // Three counters per lane. Each takes its own bit of the lane's
    // event, enable, clear and hold fields; the kind to bit mapping
    // is the same for all four fields
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            localparam integer BASE   = FIELD_W * g;
            localparam integer OUT_CC = LANE_CW * g + CNT_W * K_CC;
            localparam integer OUT_BC = LANE_CW * g + CNT_W * K_BC;
            localparam integer OUT_RD = LANE_CW * g + CNT_W * K_RD;

            wire [2:0] lane_evt;
            wire [2:0] lane_ena;
            wire [2:0] lane_clr;
            wire [2:0] lane_hold;

            assign lane_evt  = err_event_in[BASE +: FIELD_W];
            assign lane_ena  = cnt_enable_in[BASE +: FIELD_W];
            assign lane_clr  = cnt_clear_in[BASE +: FIELD_W];
            assign lane_hold = hold_bits_out[BASE +: FIELD_W];

            // Unexpected control character counter, field bit 2
            lecfg_counter u_ctrl_char (
                .clk_sys_in (clk_sys_in),
                .rst_in     (rst_in),
                .event_in   (lane_evt[K_CC]),
                .enable_in  (lane_ena[K_CC]),
                .clear_in   (lane_clr[K_CC]),
                .hold_in    (lane_hold[K_CC]),
                .count_out  (err_count_out[OUT_CC +: CNT_W])
            );

            // Invalid code group counter, field bit 1
            lecfg_counter u_bad_code (
                .clk_sys_in (clk_sys_in),
                .rst_in     (rst_in),
                .event_in   (lane_evt[K_BC]),
                .enable_in  (lane_ena[K_BC]),
                .clear_in   (lane_clr[K_BC]),
                .hold_in    (lane_hold[K_BC]),
                .count_out  (err_count_out[OUT_BC +: CNT_W])
            );

            // Running disparity counter, field bit 0
            lecfg_counter u_disparity (
                .clk_sys_in (clk_sys_in),
                .rst_in     (rst_in),
                .event_in   (lane_evt[K_RD]),
                .enable_in  (lane_ena[K_RD]),
                .clear_in   (lane_clr[K_RD]),
                .hold_in    (lane_hold[K_RD]),
                .count_out  (err_count_out[OUT_RD +: CNT_W])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Limitations
    // ------------------------------------------------------------
    // The lane 5 register sits past the last decoded address and
    // reads zero here; its writes are dropped.
    // A clear and an event in the same cycle leave the counter at
    // zero: the clear is the user's release and must not be lost.
    // Counter enables and clears arrive as plain levels because the
    // registers that hold them live outside this block.
    // The hold field is sampled by each counter at every edge, so a
    // write takes effect on the counter one cycle after it lands.
    // Nothing here watches the decoder soft reset; writing during
    // normal operation is legal for the hardware and simply takes
    // effect, which is why software owns that ordering.
    // A saturated counter stays at its terminal count only while its
    // hold bit is set: if that bit is later cleared it wraps on the
    // next counted event, which is the intended release path too.
    // All outputs come straight from registers, so no glitch from
    // the decode above can reach a pin.

endmodule // lecfg_top
`default_nettype wire

/* dv/lecfg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module lecfg_monitor (
    input wire logic        clk_sys_in,
    input wire logic        rst_in,
    input wire logic        cfg_wr_in,
    input wire logic        cfg_rd_in,
    input wire logic [11:0] cfg_addr_in,
    input wire logic [7:0]  cfg_wdata_in,
    input wire logic [7:0]  cfg_rdata_out,
    input wire logic [11:0] err_event_in,
    input wire logic [11:0] cnt_enable_in,
    input wire logic [11:0] cnt_clear_in,
    input wire logic [11:0] hold_bits_out,
    input wire logic [95:0] err_count_out
);
    wire [7:0] cnt0;
    wire       hold0;
    wire       clr0;
    wire       step0;

    assign cnt0  = err_count_out[7:0];
    assign hold0 = hold_bits_out[0];
    assign clr0  = cnt_clear_in[0];
    assign step0 = err_event_in[0] && cnt_enable_in[0];

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    sequence s_held_top;
        hold0 && cnt0 == 8'hFF && !clr0;
    endsequence
    sequence s_wrap_top;
        !hold0 && cnt0 == 8'hFF && !clr0 && step0;
    endsequence
    sequence s_write_lane1;
        cfg_wr_in && cfg_addr_in == 12'h0489;
    endsequence
    sequence s_read_lane1;
        cfg_rd_in && cfg_addr_in == 12'h0489;
    endsequence

    property p_rst;
        $fell(rst_in) |-> hold_bits_out == 12'hFFF;
    endproperty
    property p_sat;
        s_held_top |=> cnt0 == 8'hFF;
    endproperty
    property p_wrap;
        s_wrap_top |=> cnt0 == 8'h00;
    endproperty
    property p_clr;
        clr0 |=> cnt0 == 8'h00;
    endproperty
    property p_idle;
        !step0 && !clr0 |=> $stable(cnt0);
    endproperty
    property p_wr;
        s_write_lane1 |=> hold_bits_out[2:0] == $past(cfg_wdata_in[2:0]);
    endproperty
    property p_rd;
        s_read_lane1 |=> cfg_rdata_out == {5'h00, $past(hold_bits_out[2:0])};
    endproperty

    a_rst: assert property (p_rst) else $error("hold reset value");
    a_sat: assert property (p_sat) else $error("count not held");
    a_wrap: assert property (p_wrap) else $error("count no wrap");
    a_clr: assert property (p_clr) else $error("count not cleared");
    a_idle: assert property (p_idle) else $error("count moved");
    a_wr: assert property (p_wr) else $error("hold write lost");
    a_rd: assert property (p_rd) else $error("read data wrong");
endmodule // lecfg_monitor

bind lecfg_top lecfg_monitor u_mon (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .cfg_wr_in     (cfg_wr_in),
    .cfg_rd_in     (cfg_rd_in),
    .cfg_addr_in   (cfg_addr_in),
    .cfg_wdata_in  (cfg_wdata_in),
    .cfg_rdata_out (cfg_rdata_out),
    .err_event_in  (err_event_in),
    .cnt_enable_in (cnt_enable_in),
    .cnt_clear_in  (cnt_clear_in),
    .hold_bits_out (hold_bits_out),
    .err_count_out (err_count_out)
);
`default_nettype wire

/* dv/lecfg_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lecfg_top_tb_top;
    logic        clk_sys_in = 1'b0;
    logic        rst_in     = 1'b1;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic [11:0] a          = 12'h0000;
    logic [11:0] ev         = 12'h0000;
    logic [11:0] en         = 12'h0000;
    logic [11:0] cl         = 12'h0000;
    logic [11:0] hb;
    logic [7:0]  wd         = 8'h00;
    logic [7:0]  q;
    logic [95:0] n;
    int          n_errors   = 0;
    int          n_checks   = 0;

    always #4 clk_sys_in = ~clk_sys_in;

    lecfg_top u_dut (
        .clk_sys_in    (clk_sys_in),
        .rst_in        (rst_in),
        .cfg_wr_in     (wr),
        .cfg_rd_in     (rd),
        .cfg_addr_in   (a),
        .cfg_wdata_in  (wd),
        .cfg_rdata_out (q),
        .err_event_in  (ev),
        .cnt_enable_in (en),
        .cnt_clear_in  (cl),
        .err_count_out (n),
        .hold_bits_out (hb)
    );

    // Four-state compare, so an unknown counts as a mismatch
    task automatic ck(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cy(input int k);
        repeat (k) @(negedge clk_sys_in);
    endtask

    // One strobe cycle, taken at the posedge between two negedges
    task automatic ac(input bit w, input logic [11:0] d_a,
                      input logic [7:0] d);
        cy(1);
        wr = w;
        rd = !w;
        a  = d_a;
        wd = d;
        cy(1);
        wr = 1'b0;
        rd = 1'b0;
    endtask

    task automatic t_regs;
        for (int i = 0; i < 5; i++) begin
            ac(1'b0, 12'h0489 + i, 8'h00);
            ck(q, (i < 4) ? 12'h0007 : 12'h0000);
            ac(1'b1, 12'h0489 + i, 8'hF9 + i);
            ac(1'b0, 12'h0489 + i, 8'h00);
            ck(q, (i < 4) ? i + 1 : 0);
        end
        ck(hb, 12'h08D1);
        $display("t_regs done");
    endtask

    task automatic t_cnt;
        ac(1'b1, 12'h0489, 8'h06);
        ev = 12'h0001;
        cy(3);
        ck(n[7:0], 12'h0000);
        en = 12'h0001;
        cy(255);
        ck(n[7:0], 12'h00FF);
        cy(1);
        ck(n[7:0], 12'h0000);
        ev = 12'h0000;
        ac(1'b1, 12'h0489, 8'h07);
        ev = 12'h0001;
        cy(256);
        ck(n[7:0], 12'h00FF);
        cl = 12'h0001;
        cy(1);
        ck(n[7:0], 12'h0000);
        ev = 12'h0000;
        cl = 12'h0000;
        $display("t_cnt done");
    endtask

    // Lane 2 field 3'b011: control char counter wraps, others hold
    task automatic t_map;
        ac(1'b1, 12'h048A, 8'h03);
        en = 12'h0038;
        ev = 12'h0038;
        cy(255);
        ck(n[47:40], 12'h00FF);
        cy(1);
        ev = 12'h0000;
        ck(n[47:40], 12'h0000);
        ck(n[39:32], 12'h00FF);
        ck(n[31:24], 12'h00FF);
        cl = 12'h0038;
        cy(1);
        cl = 12'h0000;
        ck(n[39:32], 12'h0000);
        $display("t_map done");
    endtask

    task automatic t_reset;
        ac(1'b1, 12'h048C, 8'h00);
        rst_in = 1'b1;
        cy(2);
        rst_in = 1'b0;
        ck(hb, 12'h0FFF);
        ck(q, 12'h0000);
        cy(1);
        ac(1'b0, 12'h048C, 8'h00);
        ck(q, 12'h0007);
        $display("t_reset done");
    endtask

    task automatic wrap_up;
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        cy(6);
        rst_in = 1'b0;
        t_regs;
        t_cnt;
        t_map;
        t_reset;
        wrap_up;
    end
endmodule // lecfg_top_tb_top
`default_nettype wire
